// ==== src/ssp_port.sv ====
// synchronous serial port: spi master/slave engine and status registers
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module ssp_port (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // clock sources and two-wire engine events
  input wire logic i_timer_two_tick,
  input wire ssp_pkg::ssp_tw_evt_t i_tw_evt,
  // pins
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_ss_n,
  output ssp_pkg::ssp_pin_out_t o_pins,
  // pin ownership and two-wire pad controls
  output logic o_pins_owned,
  output logic o_ss_used,
  output logic o_slew_ctrl_en,
  output logic o_smbus_inputs,
  output logic o_tw_active
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic f_master(input logic [3:0] m);
    f_master = (m == ssp_pkg::MODE_DIV2) | (m == ssp_pkg::MODE_DIV8) |
               (m == ssp_pkg::MODE_DIV32) | (m == ssp_pkg::MODE_TIMER_TWO) |
               (m == ssp_pkg::MODE_RELOAD);
  endfunction : f_master

  function automatic logic f_slave(input logic [3:0] m);
    f_slave = (m == ssp_pkg::MODE_SLV_SS) | (m == ssp_pkg::MODE_SLV_NOSS);
  endfunction : f_slave

  function automatic logic [8:0] f_half(input logic [3:0] m,
                                        input logic [7:0] r);
    unique case (m)
      ssp_pkg::MODE_DIV8: f_half = ssp_pkg::HALF_DIV8;
      ssp_pkg::MODE_DIV32: f_half = ssp_pkg::HALF_DIV32;
      // reload zero still gives one cycle, never a stuck divider
      ssp_pkg::MODE_RELOAD: f_half = {1'b0, r} + 9'h001;
      default: f_half = ssp_pkg::HALF_DIV2;
    endcase
  endfunction : f_half

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0] sck_q;
  logic [1:0] sdi_q;
  logic [1:0] ss_q;
  logic smp_r, cke_r, da_r, stop_r, start_r, rw_r, ua_r, bf_r;
  logic write_collision_r, ovf_r, en_r, ckp_r;
  logic [3:0] mode_r;
  logic [7:0] buf_r, reload_r, tx_sr_r, rx_sr_r;
  logic [1:0] pad_r;
  logic [4:0] ctrl2_r;
  ssp_pkg::ssp_state_t state_r;
  logic [4:0] edge_r;
  logic [8:0] div_r;
  logic sck_r, sdo_r, sck_oe_r, sdo_oe_r;
  logic owned_r, ss_used_r, slew_r, smbus_r, active_r;
  logic [15:0] rdata_r;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wr_stat = i_wr & (i_addr == ssp_pkg::REG_STATUS);
  wire wr_ctrl1 = i_wr & (i_addr == ssp_pkg::REG_CTRL1);
  wire wr_buf = i_wr & (i_addr == ssp_pkg::REG_BUF);
  wire wr_reload = i_wr & (i_addr == ssp_pkg::REG_RELOAD);
  wire wr_pad = i_wr & (i_addr == ssp_pkg::REG_PAD);
  wire wr_ctrl2 = i_wr & (i_addr == ssp_pkg::REG_CTRL2);
  wire rd_buf = i_rd & (i_addr == ssp_pkg::REG_BUF);

  wire is_master = en_r & f_master(mode_r);
  wire is_slave = en_r & f_slave(mode_r);
  wire is_tw = en_r & ~f_master(mode_r) & ~f_slave(mode_r);
  wire tw_master = is_tw & ((mode_r == ssp_pkg::MODE_TW_MST) |
                            (mode_r == ssp_pkg::MODE_TW_FW));
  // select pin only counts under 0100; 0101 leaves it as plain i/o
  wire ss_ok = (mode_r == ssp_pkg::MODE_SLV_NOSS) | ~ss_q[1];
  wire sdi_s = sdi_q[1];

  // ---------------------------------------------------------------
  // shift timing
  // ---------------------------------------------------------------
  wire [8:0] half_m1 = f_half(mode_r, reload_r) - 9'h001;
  wire use_timer_two = (mode_r == ssp_pkg::MODE_TIMER_TWO);
  wire running = (state_r == ssp_pkg::ST_RUN);
  wire m_tick = running & is_master &
                (use_timer_two ? i_timer_two_tick : (div_r == half_m1));
  wire s_edge = is_slave & ss_ok & (sck_q[2] != sck_q[1]);
  wire adv = m_tick | s_edge;
  wire s_busy = edge_r != 5'h00;
  wire busy = is_master ? running : (is_slave & s_busy);

  // data out moves on trailing edges with the edge bit set
  wire shift_edge = cke_r ? edge_r[0] : ~edge_r[0];
  // slave ignores the sample bit; end-of-bit sampling applies in master modes only
  wire use_end = smp_r & is_master;
  wire end_smp = (shift_edge & ~(~cke_r & (edge_r == 5'h00))) |
                 (edge_r == ssp_pkg::EDGE_EXTRA);
  wire smp_edge = use_end ? end_smp : ~shift_edge;
  wire [4:0] last_edge = (use_end & ~cke_r) ? ssp_pkg::EDGE_EXTRA :
                         ssp_pkg::EDGE_LAST;
  wire done = adv & (edge_r == last_edge);
  wire [7:0] rx_next = smp_edge ? {rx_sr_r[6:0], sdi_s} : rx_sr_r;
  wire toggle = m_tick & (edge_r <= ssp_pkg::EDGE_LAST);

  wire start_m = wr_buf & is_master & ~running;
  wire load_s = wr_buf & is_slave & ~s_busy;
  wire load = start_m | load_s;
  wire write_collision_set = wr_buf & busy;
  wire ovf_hit = done & is_slave & bf_r;
  wire bf_set = done & ~ovf_hit;

  // ---------------------------------------------------------------
  // next values of control and status
  // ---------------------------------------------------------------
  // hardware set wins over a software clear in the same cycle
  wire write_collision_nxt = write_collision_set |
                  (write_collision_r & ~(wr_ctrl1 & ~i_wdata[ssp_pkg::C1_WRITE_COLLISION]));
  wire ovf_nxt = ovf_hit |
                 (ovf_r & ~(wr_ctrl1 & ~i_wdata[ssp_pkg::C1_OVF]));
  wire bf_nxt = bf_set | (bf_r & ~rd_buf);
  wire start_nxt = en_r & (i_tw_evt.start |
                   (start_r & ~(is_tw & i_tw_evt.stop)));
  wire stop_nxt = en_r & (i_tw_evt.stop |
                  (stop_r & ~(is_tw & i_tw_evt.start)));
  wire ua_nxt = (is_tw & i_tw_evt.update_addr) |
                (ua_r & ~wr_reload);
  wire rw_view = tw_master ? i_tw_evt.tx_busy : rw_r;
  wire bf_view = bf_r | (is_tw & i_tw_evt.tx_busy);
  wire tw_busy = rw_view | (|ctrl2_r);

  wire [7:0] stat_byte = {smp_r, cke_r, da_r, stop_r, start_r,
                          rw_view, ua_r, bf_view};
  wire [7:0] ctrl1_byte = {write_collision_r, ovf_r, en_r, ckp_r, mode_r};
  logic [7:0] rd_mux;
  always_comb begin
    unique case (i_addr)
      ssp_pkg::REG_STATUS: rd_mux = stat_byte;
      ssp_pkg::REG_CTRL1: rd_mux = ctrl1_byte;
      ssp_pkg::REG_BUF: rd_mux = buf_r;
      ssp_pkg::REG_RELOAD: rd_mux = reload_r;
      ssp_pkg::REG_PAD: rd_mux = {6'h00, pad_r};
      ssp_pkg::REG_CTRL2: rd_mux = {3'h0, ctrl2_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sck_q <= 3'h0;
      sdi_q <= 2'h0;
      ss_q <= 2'h3;
    end else begin
      sck_q <= {sck_q[1:0], i_sck};
      sdi_q <= {sdi_q[0], i_sdi};
      ss_q <= {ss_q[0], i_ss_n};
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      {smp_r, cke_r} <= 2'h0;
      {write_collision_r, ovf_r, en_r, ckp_r} <= 4'h0;
      mode_r <= ssp_pkg::RST_MODE;
      reload_r <= ssp_pkg::RST_BYTE;
      pad_r <= ssp_pkg::RST_PAD;
      ctrl2_r <= ssp_pkg::RST_CTRL2;
    end else begin
      if (wr_stat) begin
        smp_r <= i_wdata[ssp_pkg::ST_SMP];
        cke_r <= i_wdata[ssp_pkg::ST_CKE];
      end
      if (wr_ctrl1) begin
        en_r <= i_wdata[ssp_pkg::C1_EN];
        ckp_r <= i_wdata[ssp_pkg::C1_CKP];
        mode_r <= i_wdata[3:0];
      end
      write_collision_r <= write_collision_nxt;
      ovf_r <= ovf_nxt;
      if (wr_reload) begin
        reload_r <= i_wdata[7:0];
      end
      if (wr_pad) begin
        pad_r <= i_wdata[1:0];
      end
      if (wr_ctrl2) begin
        ctrl2_r <= i_wdata[4:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // two-wire status view
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      {da_r, stop_r, start_r, rw_r, ua_r} <= 5'h00;
    end else begin
      start_r <= start_nxt;
      stop_r <= stop_nxt;
      ua_r <= ua_nxt;
      if (!is_tw || tw_master) begin
        da_r <= 1'b0; // reserved outside two-wire slave
      end else if (i_tw_evt.data_byte || i_tw_evt.addr_byte) begin
        da_r <= i_tw_evt.data_byte;
      end
      if (is_tw && i_tw_evt.addr_byte) begin
        rw_r <= i_tw_evt.rw;
      end
    end
  end

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst || !en_r) begin
      state_r <= ssp_pkg::ST_IDLE;
      edge_r <= 5'h00;
      div_r <= 9'h000;
      tx_sr_r <= ssp_pkg::RST_BYTE;
      rx_sr_r <= ssp_pkg::RST_BYTE;
      sdo_r <= 1'b0;
    end else begin
      if (start_m) begin
        state_r <= ssp_pkg::ST_RUN;
      end else if (done && is_master) begin
        state_r <= ssp_pkg::ST_IDLE;
      end
      if (running && !use_timer_two && div_r != half_m1) begin
        div_r <= div_r + 9'h001;
      end else begin
        div_r <= 9'h000;
      end
      if (is_slave && !ss_ok) begin
        edge_r <= 5'h00; // deselect aborts a partial frame
      end else if (done) begin
        edge_r <= 5'h00;
      end else if (adv) begin
        edge_r <= edge_r + 5'h01;
      end
      // msb first; edge bit set puts the msb out before the first edge
      if (load) begin
        tx_sr_r <= cke_r ? {i_wdata[6:0], 1'b0} : i_wdata[7:0];
        if (cke_r) begin
          sdo_r <= i_wdata[7];
        end
      end else if (adv && shift_edge && edge_r <= ssp_pkg::EDGE_LAST) begin
        sdo_r <= tx_sr_r[7];
        tx_sr_r <= {tx_sr_r[6:0], 1'b0};
      end
      if (adv) begin
        rx_sr_r <= rx_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive buffer
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      buf_r <= ssp_pkg::RST_BYTE;
      bf_r <= 1'b0;
    end else begin
      if (bf_set) begin
        buf_r <= rx_next;
      end
      bf_r <= bf_nxt;
    end
  end

  // ---------------------------------------------------------------
  // pins and pad controls
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sck_r <= 1'b0;
      {sck_oe_r, sdo_oe_r} <= 2'h0;
      {owned_r, ss_used_r, slew_r, smbus_r, active_r} <= 5'h00;
    end else begin
      if (!running) begin
        sck_r <= ckp_r;
      end else if (toggle) begin
        sck_r <= ~sck_r;
      end
      sck_oe_r <= is_master & ~pad_r[ssp_pkg::PAD_SCK_DIS];
      sdo_oe_r <= (is_master | (is_slave & ss_ok)) &
                  ~pad_r[ssp_pkg::PAD_SDO_DIS];
      owned_r <= en_r;
      ss_used_r <= en_r & (mode_r == ssp_pkg::MODE_SLV_SS);
      slew_r <= is_tw & ~smp_r;
      smbus_r <= is_tw & cke_r;
      active_r <= is_tw & tw_busy;
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= i_rd ? {8'h00, rd_mux} : 16'h0000;
    end
  end

  assign o_rdata = rdata_r;
  assign o_pins = '{sck: sck_r, sck_oe: sck_oe_r,
                    sdo: sdo_r, sdo_oe: sdo_oe_r};
  assign o_pins_owned = owned_r;
  assign o_ss_used = ss_used_r;
  assign o_slew_ctrl_en = slew_r;
  assign o_smbus_inputs = smbus_r;
  assign o_tw_active = active_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  sequence s_div8_tick;
    is_master && mode_r == ssp_pkg::MODE_DIV8 && m_tick &&
      edge_r < 5'h0c && !wr_ctrl1;
  endsequence
  sequence s_div8_gap;
    !m_tick [*3] ##1 m_tick;
  endsequence

  AST_DIV8_RATE: assert property (s_div8_tick |=> s_div8_gap)
    else $error("divide-by-8 clock half period wrong");
  AST_SCK_IDLE: assert property (
    is_master && !running |=> sck_r == $past(ckp_r))
    else $error("serial clock not at idle level");
  AST_SDO_HOLD: assert property (
    adv && !shift_edge && !load |=> $stable(sdo_r))
    else $error("data out moved on the wrong clock edge");
  AST_OVF_SLAVE: assert property (
    ovf_hit |=> ovf_r && buf_r == $past(buf_r))
    else $error("slave overflow not flagged or buffer overwritten");
  AST_NO_OVF_MASTER: assert property (
    is_master |=> !$rose(ovf_r))
    else $error("overflow set in master mode");
  AST_BF_RX: assert property (
    bf_set |=> bf_r && buf_r == $past(rx_next))
    else $error("completed byte not in buffer");
  AST_WRITE_COLLISION_SET: assert property (
    wr_buf && busy |=> write_collision_r ##1 (write_collision_r || $past(wr_ctrl1)))
    else $error("write collision not held");
  AST_DISABLE_CLR: assert property (
    !en_r |=> !stop_r && !start_r)
    else $error("stop or start seen survives disable");
  AST_PINS_FREE: assert property (
    !en_r |=> !sck_oe_r && !sdo_oe_r && !owned_r)
    else $error("pins still driven while disabled");
  AST_SCK_DISC: assert property (
    pad_r[ssp_pkg::PAD_SCK_DIS] |=> !sck_oe_r)
    else $error("clock output not disconnected");
  AST_SLEW: assert property (
    is_tw && !smp_r |=> o_slew_ctrl_en)
    else $error("slew control not enabled");
  AST_FRAME_LEN: assert property (
    start_m && mode_r == ssp_pkg::MODE_DIV2 && !smp_r && !wr_ctrl1
    |=> running [*8])
    else $error("frame ended early");
endmodule : ssp_port
`default_nettype wire

// ==== src/ssp_pkg.sv ====
// register map, field layout, modes and carriers of the serial port
package ssp_pkg;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL1 = 4'h1;
  localparam logic [3:0] REG_BUF = 4'h2;
  localparam logic [3:0] REG_RELOAD = 4'h3;
  localparam logic [3:0] REG_PAD = 4'h4;
  localparam logic [3:0] REG_CTRL2 = 4'h5;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ST_SMP = 7;
  localparam int ST_CKE = 6;
  localparam int ST_DA = 5;
  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_RW = 2;
  localparam int ST_UA = 1;
  localparam int ST_BF = 0;
  localparam int C1_WRITE_COLLISION = 7;
  localparam int C1_OVF = 6;
  localparam int C1_EN = 5;
  localparam int C1_CKP = 4;
  localparam int PAD_SDO_DIS = 0;
  localparam int PAD_SCK_DIS = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_MODE = 4'h0;
  localparam logic [4:0] RST_CTRL2 = 5'h00;
  localparam logic [1:0] RST_PAD = 2'h0;
  // ---------------------------------------------------------------
  // mode codes and half-period counts
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_DIV2 = 4'h0;
  localparam logic [3:0] MODE_DIV8 = 4'h1;
  localparam logic [3:0] MODE_DIV32 = 4'h2;
  localparam logic [3:0] MODE_TIMER_TWO = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
  localparam logic [3:0] MODE_RELOAD = 4'ha;
  localparam logic [3:0] MODE_TW_MST = 4'h8;
  localparam logic [3:0] MODE_TW_FW = 4'hb;
  localparam logic [8:0] HALF_DIV2 = 9'h001;
  localparam logic [8:0] HALF_DIV8 = 9'h004;
  localparam logic [8:0] HALF_DIV32 = 9'h010;
  localparam logic [4:0] EDGE_LAST = 5'h0f;
  localparam logic [4:0] EDGE_EXTRA = 5'h10;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } ssp_state_t;
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic sdo;
    logic sdo_oe;
  } ssp_pin_out_t;
  typedef struct packed {
    logic start;
    logic stop;
    logic data_byte;
    logic addr_byte;
    logic rw;
    logic update_addr;
    logic tx_busy;
  } ssp_tw_evt_t;
endpackage : ssp_pkg

// ==== test/ssp_peer.sv ====
// far-side spi peripheral: slave to a master port, master to a slave port
`timescale 1ns/100ps
`default_nettype none
module ssp_peer (
  // pins coming from the port
  input wire logic i_sck,
  input wire logic i_sdo,
  input wire logic i_sel,
  // pins driven towards the port
  output logic o_sdi,
  output logic o_sck,
  output logic o_ss_n
);
  logic [7:0] tx_r = 8'h00;
  logic [7:0] rx_r = 8'h00;
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_sdi = 1'b0;
  end
  // ---------------------------------------------------------------
  // slave role: clock idles low, sample rising, shift on falling
  // ---------------------------------------------------------------
  always @(posedge i_sck) if (i_sel) rx_r = {rx_r[6:0], i_sdo};
  always @(negedge i_sck) if (i_sel) begin
    tx_r = {tx_r[6:0], ~tx_r[0]};
    o_sdi = tx_r[7];
  end
  // released line shows no stale bit
  always @(negedge i_sel) o_sdi = ~o_sdi;
  task automatic load(input logic [7:0] b);
    tx_r = b;
    o_sdi = b[7];
  endtask : load
  // ---------------------------------------------------------------
  // master role: 80 ns halves, clock still outside the frame
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    #3 o_ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      o_sdi = b[i];
      #80 o_sck = 1'b1;
      rx_r = {rx_r[6:0], i_sdo};
      #80 o_sck = 1'b0;
    end
    #80 o_ss_n = 1'b1;
    o_sdi = ~o_sdi;
  endtask : send
endmodule : ssp_peer
`default_nettype wire

// ==== test/ssp_port_tb_top.sv ====
// self-checking bench: master clock rows, then slave and status cases
`timescale 1ns/100ps
`default_nettype none
module ssp_port_tb_top;
  typedef struct packed {
    logic [3:0] mode;
    logic [7:0] rld;
    logic [8:0] half;
    logic [7:0] tx;
    logic [7:0] rx;
    logic chk_rx;
  } ssp_row_t;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic tick = 1'b0;
  logic sel = 1'b0;
  logic [1:0] tcnt = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, d;
  ssp_pkg::ssp_tw_evt_t tw = '0;
  ssp_pkg::ssp_pin_out_t pins;
  logic owned, ss_used, slew, smb, tw_act, sdi, sck_in, ss_n;
  int n_errors = 0;
  int n_tests = 0;
  int half;
  // /2 data-in is left unchecked: the clock outruns the input synchroniser
  ssp_row_t rows [5] = '{
    '{ssp_pkg::MODE_DIV2, 8'h00, ssp_pkg::HALF_DIV2, 8'ha5, 8'h00, 1'b0},
    '{ssp_pkg::MODE_DIV8, 8'h00, ssp_pkg::HALF_DIV8, 8'h3c, 8'h96, 1'b1},
    '{ssp_pkg::MODE_DIV32, 8'h00, ssp_pkg::HALF_DIV32, 8'h81, 8'h7e, 1'b1},
    '{ssp_pkg::MODE_TIMER_TWO, 8'h00, 9'h004, 8'h0f, 8'hc6, 1'b1},
    '{ssp_pkg::MODE_RELOAD, 8'h03, 9'h004, 8'hf0, 8'h35, 1'b1}};
  ssp_port ssp_port_i (
    .i_mclk(mclk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_timer_two_tick(tick),
    .i_tw_evt(tw), .i_sck(sck_in), .i_sdi(sdi), .i_ss_n(ss_n),
    .o_pins(pins), .o_pins_owned(owned), .o_ss_used(ss_used),
    .o_slew_ctrl_en(slew), .o_smbus_inputs(smb), .o_tw_active(tw_act));
  ssp_peer ssp_peer_i (
    .i_sck(pins.sck), .i_sdo(pins.sdo), .i_sel(sel), .o_sdi(sdi),
    .o_sck(sck_in), .o_ss_n(ss_n));
  initial forever #5 mclk = ~mclk;
  // timer-two pulse every fourth cycle
  always @(posedge mclk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end
  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_n(input int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask : wait_n
  task automatic measure(output int n);
    logic s;
    int k;
    @(negedge mclk);
    s = pins.sck;
    k = 0;
    while (pins.sck === s && k < 400) begin
      @(negedge mclk);
      k++;
    end
    s = pins.sck;
    n = 0;
    while (pins.sck === s && n < 400) begin
      @(negedge mclk);
      n++;
    end
  endtask : measure
  task automatic wait_bf();
    int k;
    d = 16'h0000;
    k = 0;
    while (d[0] !== 1'b1 && k < 300) begin
      rd(ssp_pkg::REG_STATUS, d);
      k++;
    end
    chk("status full", d, 16'h0041);
  endtask : wait_bf
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd(ssp_pkg::REG_STATUS, d);
    chk("status reset", d, 16'h0000);
    rd(ssp_pkg::REG_CTRL1, d);
    chk("ctrl reset", d, 16'h0000);
    rd(4'hf, d);
    chk("unmapped", d, 16'h0000);
    chk("pins reset", {12'h000, pins}, 16'h0000);
    foreach (rows[i]) begin
      wr(ssp_pkg::REG_CTRL1, {12'h002, rows[i].mode});
      wr(ssp_pkg::REG_STATUS, 16'h0040);
      wr(ssp_pkg::REG_RELOAD, {8'h00, rows[i].rld});
      ssp_peer_i.load(rows[i].rx);
      sel = 1'b1;
      wr(ssp_pkg::REG_BUF, {8'h00, rows[i].tx});
      measure(half);
      chk("half period", 16'(half), 16'(rows[i].half));
      wait_bf();
      sel = 1'b0;
      chk("peer rx", {8'h00, ssp_peer_i.rx_r}, {8'h00, rows[i].tx});
      rd(ssp_pkg::REG_BUF, d);
      if (rows[i].chk_rx) chk("buffer", d, {8'h00, rows[i].rx});
      rd(ssp_pkg::REG_STATUS, d);
      chk("status empty", d, 16'h0040);
    end
    // idle high clock, collision, no master overflow
    wr(ssp_pkg::REG_CTRL1, 16'h0032);
    wait_n(3);
    chk("idle pins", {12'h000, owned, pins.sck, pins.sck_oe, pins.sdo_oe},
        16'h000f);
    wr(ssp_pkg::REG_BUF, 16'h0011);
    wr(ssp_pkg::REG_BUF, 16'h0022);
    rd(ssp_pkg::REG_CTRL1, d);
    chk("collision", d, 16'h00b2);
    wait_bf();
    wr(ssp_pkg::REG_CTRL1, 16'h0032);
    wr(ssp_pkg::REG_BUF, 16'h0033);
    wait_n(300);
    rd(ssp_pkg::REG_CTRL1, d);
    chk("master ovf", d, 16'h0032);
    // empty the buffer so the first slave byte is not an overflow
    rd(ssp_pkg::REG_BUF, d);
    rd(ssp_pkg::REG_STATUS, d);
    chk("master drained", d, 16'h0040);
    wr(ssp_pkg::REG_PAD, 16'h0003);
    wait_n(2);
    chk("disconnect", {14'h0, pins.sck_oe, pins.sdo_oe}, 16'h0000);
    wr(ssp_pkg::REG_PAD, 16'h0000);
    wr(ssp_pkg::REG_CTRL1, 16'h0000);
    wait_n(2);
    chk("released", {14'h0, owned, pins.sck_oe}, 16'h0000);
    // slave with select, then overflow on an unread buffer
    wr(ssp_pkg::REG_CTRL1, 16'h0024);
    wr(ssp_pkg::REG_BUF, 16'h00c3);
    wait_n(2);
    chk("select used", {15'h0, ss_used}, 16'h0001);
    ssp_peer_i.send(8'h5a);
    wait_n(8);
    chk("slave tx", {8'h00, ssp_peer_i.rx_r}, 16'h00c3);
    rd(ssp_pkg::REG_STATUS, d);
    chk("slave full", d, 16'h0041);
    ssp_peer_i.send(8'h77);
    wait_n(8);
    rd(ssp_pkg::REG_CTRL1, d);
    chk("overflow", d, 16'h0064);
    rd(ssp_pkg::REG_BUF, d);
    chk("kept byte", d, 16'h005a);
    wr(ssp_pkg::REG_CTRL1, 16'h0025);
    wait_n(2);
    chk("select free", {15'h0, ss_used}, 16'h0000);
    // two-wire status view
    wr(ssp_pkg::REG_CTRL1, 16'h0028);
    wr(ssp_pkg::REG_CTRL2, 16'h0001);
    wait_n(2);
    chk("pad modes", {13'h0, slew, smb, tw_act}, 16'h0007);
    @(posedge mclk);
    tw.stop <= 1'b1;
    @(posedge mclk);
    tw.stop <= 1'b0;
    rd(ssp_pkg::REG_STATUS, d);
    chk("stop seen", d, 16'h0050);
    // two-wire slave: address byte, then data byte with a start
    wr(ssp_pkg::REG_CTRL1, 16'h0026);
    @(posedge mclk);
    tw.addr_byte <= 1'b1;
    tw.rw <= 1'b1;
    tw.update_addr <= 1'b1;
    @(posedge mclk);
    tw <= '0;
    rd(ssp_pkg::REG_STATUS, d);
    chk("address byte", d, 16'h0056);
    @(posedge mclk);
    tw.data_byte <= 1'b1;
    tw.start <= 1'b1;
    @(posedge mclk);
    tw <= '0;
    rd(ssp_pkg::REG_STATUS, d);
    chk("data byte", d, 16'h006e);
    wr(ssp_pkg::REG_RELOAD, 16'h0000);
    rd(ssp_pkg::REG_STATUS, d);
    chk("address updated", d, 16'h006c);
    wr(ssp_pkg::REG_CTRL1, 16'h0008);
    rd(ssp_pkg::REG_STATUS, d);
    chk("stop cleared", d, 16'h0044);
    end_of_test();
  end
endmodule : ssp_port_tb_top
`default_nettype wire
